// *** tgc_consts.vh ***
// Constants shared by the time gate controller.
// Assumes inclusion by bare name from the design file only.
`ifndef TGC_CONSTS_VH
`define TGC_CONSTS_VH

// =============================================================
// Clock and timing
`define TGC_CLK_HZ          32'd125000000
// Capture time factor 1.83 held in hundredths.
`define TGC_CAP_FACTOR_X100 32'd183
`define TGC_PCT_DIV         32'd100
`define TGC_CAP_NUM         (`TGC_CAP_FACTOR_X100 * (`TGC_CLK_HZ / `TGC_PCT_DIV))
// Steps of the capture length divider, one quotient bit each.
`define TGC_DIV_STEPS       6'h20

// =============================================================
// Limits and defaults
`define TGC_FFT_MAX_SPAN_HZ 32'd10000000
`define TGC_DEF_POINTS      16'd401

// =============================================================
// Gating method codes
`define TGC_METH_NONE       2'h0
`define TGC_METH_FFT        2'h1
`define TGC_METH_VIDEO      2'h2
`define TGC_METH_SWEEP      2'h3

`endif

// *** tgc_gate_ctrl.v ***
// Time gate controller: trigger synchroniser, level gate, edge gate with
// delay and length, gated FFT capture, gated video and gated sweep ramp.
// Assumes one 125 MHz core clock with synchronous reset; the gate trigger
// pin is asynchronous; configuration ports are static around I_START.
`include "tgc_consts.vh"

module tgc_gate_ctrl #(
  parameter CW = 32,
  parameter VW = 16,
  parameter SW = 16,
  parameter RW = 24,
  parameter PW = 16
) (
  // Clock and reset
  input  wire          I_CORE_CLK,
  input  wire          I_RESET,
  // Gate trigger pin
  input  wire          I_GATE_TRIG,
  // Measurement configuration
  input  wire          I_START,
  input  wire          I_STOP,
  input  wire          I_EDGE_MODE,
  input  wire [1:0]    I_METHOD,
  input  wire [CW-1:0] I_GATE_DELAY,
  input  wire [CW-1:0] I_GATE_LENGTH,
  input  wire [31:0]   I_RESOLUTION_BANDWIDTH_SETTING,
  input  wire [31:0]   I_SPAN_HZ,
  input  wire [PW-1:0] I_DISPLAY_POINTS,
  input  wire [CW-1:0] I_BURST_CYCLE,
  input  wire [CW+PW-1:0] I_SWEEP_TIME,
  // Data paths
  input  wire [SW-1:0] I_IF_SAMPLE,
  input  wire [VW-1:0] I_VIDEO,
  input  wire [RW-1:0] I_RAMP_STEP,
  // Status
  output reg           O_RUNNING,
  output reg           O_GATE_OPEN,
  output reg           O_FFT_DENIED,
  output reg           O_SWEEP_TOO_SHORT,
  output reg  [CW+PW-1:0] O_MIN_SWEEP,
  output reg           O_PEAK_DET,
  // Capture stream
  output reg           O_CAP_VALID,
  output reg  [SW-1:0] O_CAP_DATA,
  output reg           O_CAP_LAST,
  // Video and ramp
  output reg  [VW-1:0] O_VIDEO,
  output reg  [RW-1:0] O_RAMP
);

  localparam [2:0] ST_IDLE  = 3'h1;
  localparam [2:0] ST_DELAY = 3'h2;
  localparam [2:0] ST_OPEN  = 3'h4;
  localparam [5:0] DIV_STEPS = `TGC_DIV_STEPS;

  // =============================================================
  // Trigger synchroniser
  reg trig_m;
  reg trig_s;
  reg trig_d;
  always @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      trig_m <= 1'b0;
      trig_s <= 1'b0;
      trig_d <= 1'b0;
    end else begin
      trig_m <= I_GATE_TRIG;
      trig_s <= trig_m;
      trig_d <= trig_s;
    end
  end
  wire trig_rise = trig_s & ~trig_d;

  // =============================================================
  // Configuration latched at start
  reg          run;
  reg          edge_mode;
  reg [1:0]    method;
  reg [CW-1:0] delay_cfg;
  reg [CW-1:0] length_cfg;
  wire fft_ok = (I_SPAN_HZ <= `TGC_FFT_MAX_SPAN_HZ);
  wire start_ok = I_START & ~((I_METHOD == `TGC_METH_FFT) & ~fft_ok);

  always @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      run        <= 1'b0;
      edge_mode  <= 1'b0;
      method     <= `TGC_METH_NONE;
      delay_cfg  <= {CW{1'b0}};
      length_cfg <= {CW{1'b0}};
    end else begin
      if (I_STOP) begin
        run <= 1'b0;
      end else if (start_ok) begin
        run        <= 1'b1;
        edge_mode  <= I_EDGE_MODE;
        method     <= I_METHOD;
        delay_cfg  <= I_GATE_DELAY;
        length_cfg <= I_GATE_LENGTH;
      end
    end
  end

  // =============================================================
  // Capture length divider: cycles = factor * clock / bandwidth
  reg [31:0] div_q;
  reg [31:0] div_r;
  reg [31:0] div_d;
  reg [5:0]  div_n;
  reg        div_busy;
  reg [31:0] cap_len;
  wire [32:0] div_trial = {div_r, div_q[31]} - {1'b0, div_d};

  always @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      div_q    <= 32'h0;
      div_r    <= 32'h0;
      div_d    <= 32'h0;
      div_n    <= 6'h0;
      div_busy <= 1'b0;
      cap_len  <= 32'h1;
    end else if (start_ok) begin
      div_q    <= `TGC_CAP_NUM;
      div_r    <= 32'h0;
      div_d    <= (I_RESOLUTION_BANDWIDTH_SETTING == 32'h0) ? 32'h1
                  : I_RESOLUTION_BANDWIDTH_SETTING;
      div_n    <= DIV_STEPS;
      div_busy <= 1'b1;
    end else if (div_busy) begin
      if (div_trial[32]) begin
        div_r <= {div_r[30:0], div_q[31]};
        div_q <= {div_q[30:0], 1'b0};
      end else begin
        div_r <= div_trial[31:0];
        div_q <= {div_q[30:0], 1'b1};
      end
      div_n <= div_n - 6'h1;
      if (div_n == 6'h1) begin
        div_busy <= 1'b0;
        cap_len  <= (div_trial[32] && div_q[30:0] == 31'h0) ? 32'h1
                    : {div_q[30:0], ~div_trial[32]};
      end
    end
  end

  // =============================================================
  // Edge gate sequencer
  reg [2:0]    state;
  reg [2:0]    next_state;
  reg [CW-1:0] cnt;
  reg [CW-1:0] next_cnt;
  wire is_fft = (method == `TGC_METH_FFT);
  wire [CW-1:0] open_len = is_fft ? cap_len[CW-1:0] : length_cfg;
  wire [CW-1:0] open_load = (open_len == {CW{1'b0}}) ? {CW{1'b0}}
                            : open_len - {{(CW-1){1'b0}}, 1'b1};

  always @* begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      ST_IDLE: begin
        if (run && edge_mode && !div_busy && trig_rise) begin
          if (delay_cfg == {CW{1'b0}}) begin
            next_state = ST_OPEN;
            next_cnt   = open_load;
          end else begin
            next_state = ST_DELAY;
            next_cnt   = delay_cfg - {{(CW-1){1'b0}}, 1'b1};
          end
        end
      end
      ST_DELAY: begin
        if (cnt == {CW{1'b0}}) begin
          next_state = ST_OPEN;
          next_cnt   = open_load;
        end else begin
          next_cnt = cnt - {{(CW-1){1'b0}}, 1'b1};
        end
      end
      ST_OPEN: begin
        if (cnt == {CW{1'b0}}) begin
          next_state = ST_IDLE;
        end else begin
          next_cnt = cnt - {{(CW-1){1'b0}}, 1'b1};
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_cnt   = {CW{1'b0}};
      end
    endcase
    if (!run) begin
      next_state = ST_IDLE;
    end
  end

  always @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      state <= ST_IDLE;
      cnt   <= {CW{1'b0}};
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // Gate is open from level in level mode, from the sequencer in edge mode.
  wire gate = run & (edge_mode ? (state == ST_OPEN) : (trig_s & ~div_busy));

  // =============================================================
  // Level mode FFT capture length counter
  reg [31:0] lvl_cnt;
  wire lvl_done = (lvl_cnt == 32'h0);
  always @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      lvl_cnt <= 32'h0;
    end else if (!gate) begin
      lvl_cnt <= cap_len - 32'h1;
    end else if (!lvl_done) begin
      lvl_cnt <= lvl_cnt - 32'h1;
    end
  end
  reg lvl_spent;
  always @(posedge I_CORE_CLK) begin
    if (I_RESET || !gate) begin
      lvl_spent <= 1'b0;
    end else if (lvl_done) begin
      lvl_spent <= 1'b1;
    end
  end

  wire cap_en = is_fft & gate & (edge_mode | ~lvl_spent);
  wire cap_end = edge_mode ? (cnt == {CW{1'b0}}) : lvl_done;

  // =============================================================
  // Registered outputs
  wire [CW+PW-1:0] min_sweep = I_DISPLAY_POINTS * I_BURST_CYCLE;
  wire is_video = (method == `TGC_METH_VIDEO);
  wire is_sweep = (method == `TGC_METH_SWEEP);

  always @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      O_RUNNING         <= 1'b0;
      O_GATE_OPEN       <= 1'b0;
      O_FFT_DENIED      <= 1'b0;
      O_SWEEP_TOO_SHORT <= 1'b0;
      O_MIN_SWEEP       <= {(CW+PW){1'b0}};
      O_PEAK_DET        <= 1'b0;
      O_CAP_VALID       <= 1'b0;
      O_CAP_DATA        <= {SW{1'b0}};
      O_CAP_LAST        <= 1'b0;
      O_VIDEO           <= {VW{1'b0}};
      O_RAMP            <= {RW{1'b0}};
    end else begin
      O_RUNNING         <= run;
      O_GATE_OPEN       <= gate;
      O_FFT_DENIED      <= (I_METHOD == `TGC_METH_FFT) & ~fft_ok;
      O_MIN_SWEEP       <= min_sweep;
      O_SWEEP_TOO_SHORT <= (I_METHOD == `TGC_METH_VIDEO) & (I_SWEEP_TIME < min_sweep);
      O_PEAK_DET        <= run & is_video;
      O_CAP_VALID       <= cap_en;
      O_CAP_DATA        <= cap_en ? I_IF_SAMPLE : {SW{1'b0}};
      O_CAP_LAST        <= cap_en & cap_end;
      O_VIDEO           <= (is_video && !gate) ? {VW{1'b0}} : I_VIDEO;
      if (start_ok) begin
        O_RAMP <= {RW{1'b0}};
      end else if (run && (!is_sweep || gate)) begin
        O_RAMP <= O_RAMP + I_RAMP_STEP;
      end
    end
  end

endmodule // tgc_gate_ctrl

// *** tgc_trig_src.sv ***
// Gate trigger source model driving the trigger pin.
// Assumes a one-cycle fire request from the bench.
module tgc_trig_src (
  // Request and pin
  input  wire       clk,
  input  wire       fire,
  input  wire [7:0] hi,
  output wire       trig
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left = 8'h0;
  // ==========
  // Holds the pin high for the requested count, low when idle.
  always @(posedge clk) begin
    if (fire) left <= hi;
    else if (left != 8'h0) left <= left - 8'h1;
  end
  assign trig = left != 8'h0;
endmodule // tgc_trig_src

// *** tgc_gate_ctrl_properties.sv ***
// Checker bound to the time gate controller top module.
// Assumes one core clock and a synchronous active-high reset.
module tgc_gate_ctrl_chk #(parameter CW = 32, parameter VW = 16, parameter RW = 24) (
  // Inputs of the block
  input wire          I_CORE_CLK, I_RESET, I_START, I_STOP, I_EDGE_MODE, I_GATE_TRIG,
  input wire [1:0]    I_METHOD,
  input wire [31:0]   I_SPAN_HZ,
  input wire [CW-1:0] I_GATE_LENGTH,
  input wire [RW-1:0] I_RAMP_STEP,
  // Outputs of the block
  input wire          O_RUNNING, O_GATE_OPEN, O_FFT_DENIED, O_PEAK_DET,
  input wire [VW-1:0] O_VIDEO,
  input wire [RW-1:0] O_RAMP
);
  logic [1:0]    meth;
  logic          edg;
  logic [CW-1:0] len;
  logic [CW-1:0] cnt;
  wire deny = I_METHOD == 2'h1 && I_SPAN_HZ > 32'h00989680;
  wire take = I_START && !I_STOP && !deny;
  // ==========
  // Settings of the run in progress and the length of the open gate.
  always @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      meth <= 2'h0;
      edg  <= 1'h0;
      len  <= '0;
    end else if (take) begin
      meth <= I_METHOD;
      edg  <= I_EDGE_MODE;
      len  <= I_GATE_LENGTH;
    end
  end
  always @(posedge I_CORE_CLK) begin
    cnt <= O_GATE_OPEN ? cnt + 1'h1 : '0;
  end
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RESET);
  // ==========
  // Assertions.
  a_start_runs: assert property (take |-> ##2 O_RUNNING)
    else $error("Start left block idle.");
  a_level_gate: assert property (!edg && O_RUNNING && $rose(I_GATE_TRIG) |-> ##[2:4] O_GATE_OPEN)
    else $error("Level gate did not open.");
  a_open_len: assert property (edg && meth != 2'h1 && $fell(O_GATE_OPEN) |-> cnt == len)
    else $error("Open gate length wrong.");
  a_fft_refuse: assert property (deny |-> ##[0:1] O_FFT_DENIED)
    else $error("Wide span not refused.");
  a_video_blank: assert property (meth == 2'h2 && O_RUNNING && !O_GATE_OPEN && !$past(take)
    |-> O_VIDEO == '0) else $error("Blocked video not minimum.");
  a_peak_forced: assert property ($rose(O_RUNNING) && meth == 2'h2 |-> O_PEAK_DET)
    else $error("Peak detect not forced.");
  a_ramp_hold: assert property (meth == 2'h3 && O_RUNNING && !O_GATE_OPEN && !$past(take)
    |-> $stable(O_RAMP)) else $error("Ramp moved while blocked.");
  a_ramp_step: assert property (meth == 2'h3 && O_GATE_OPEN && !$past(take)
    |-> O_RAMP == $past(O_RAMP) + $past(I_RAMP_STEP)) else $error("Ramp step wrong.");
endmodule // tgc_gate_ctrl_chk
bind tgc_gate_ctrl tgc_gate_ctrl_chk #(.CW(CW), .VW(VW), .RW(RW)) u_chk (.*);

// *** tgc_gate_ctrl_bench.sv ***
// Self-checking bench for the time gate controller.
// Assumes the trigger source model and the checker are compiled first.
module tgc_gate_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'h0, rst = 1'h1, st = 1'h0, sp = 1'h0, em = 1'h0, fire = 1'h0;
  logic [1:0]  me = 2'h0;
  logic [7:0]  hi = 8'h0;
  logic [15:0] vid = 16'h0;
  logic [31:0] dl = 32'h0, ln = 32'h1, spn = 32'h000f4240;
  logic [47:0] sw = 48'h0, msw;
  logic        trig, run, gopen, fden, sshort, pk, cv, cl;
  logic [15:0] cd, vo;
  logic [23:0] rmp;
  int          fails = 0, comparisons = 0, first, opens, vals, lasts;
  always #4 clk = ~clk;
  always @(posedge clk) vid <= vid + 16'h0101;
  tgc_trig_src u_src (.clk(clk), .fire(fire), .hi(hi), .trig(trig));
  tgc_gate_ctrl DUT (
    .I_CORE_CLK(clk), .I_RESET(rst), .I_GATE_TRIG(trig), .I_START(st), .I_STOP(sp),
    .I_EDGE_MODE(em), .I_METHOD(me), .I_GATE_DELAY(dl), .I_GATE_LENGTH(ln),
    .I_RESOLUTION_BANDWIDTH_SETTING(32'h02ba16f0), .I_SPAN_HZ(spn),
    .I_DISPLAY_POINTS(16'h0191), .I_BURST_CYCLE(32'h0000000a), .I_SWEEP_TIME(sw),
    .I_IF_SAMPLE(vid), .I_VIDEO(vid), .I_RAMP_STEP(24'h000123),
    .O_RUNNING(run), .O_GATE_OPEN(gopen), .O_FFT_DENIED(fden), .O_SWEEP_TOO_SHORT(sshort),
    .O_MIN_SWEEP(msw), .O_PEAK_DET(pk), .O_CAP_VALID(cv), .O_CAP_DATA(cd),
    .O_CAP_LAST(cl), .O_VIDEO(vo), .O_RAMP(rmp));
  task automatic chk(input string nm, input logic [47:0] e, g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic go(input logic e, input logic [1:0] m, input logic [31:0] d, l);
    @(posedge clk);
    {em, me, dl, ln, st} <= {e, m, d, l, 1'h1};
    @(posedge clk);
    st <= 1'h0;
    repeat (40) @(posedge clk);
  endtask
  // Fires a trigger burst at the first cycle and another at cycle p2 if in range, while tallying gate and capture outputs.
  task automatic watch(input logic [7:0] h, input int p2);
    {first, opens, vals, lasts} = {-32'sd1, 96'h0};
    for (int j = 0; j < 40; j++) begin
      @(posedge clk);
      fire <= (j == 0 || j == p2);
      hi <= h;
      #1;
      if (gopen === 1'h1 && first < 0) first = j;
      opens += (gopen === 1'h1);
      vals += (cv === 1'h1);
      lasts += (cl === 1'h1);
      if (cv === 1'h1) chk("cap_data", 16'(vid - 16'h0101), cd);
      if (pk === 1'h1 && gopen === 1'h1) chk("video", 16'(vid - 16'h0101), vo);
    end
  endtask
  task automatic t_edge_video;
    go(1'h1, 2'h2, 32'h2, 32'h3);
    watch(8'h2, 4);
    chk("first_open", 48'h7, first);
    chk("open_cycles", 48'h3, opens);
    chk("peak_det", 48'h1, pk);
  endtask
  task automatic t_zero_sweep;
    go(1'h1, 2'h3, 32'h0, 32'h4);
    watch(8'h2, -1);
    chk("first_open", 48'h5, first);
    chk("open_cycles", 48'h4, opens);
    chk("ramp", 48'h48c, rmp);
  endtask
  task automatic t_fft;
    go(1'h1, 2'h1, 32'h1, 32'h1);
    watch(8'h2, -1);
    chk("first_valid", 48'h6, first);
    chk("valid_cycles", 48'h5, vals);
    chk("last_pulses", 48'h1, lasts);
  endtask
  task automatic t_level;
    go(1'h0, 2'h0, 32'h0, 32'h1);
    watch(8'h0a, -1);
    chk("open_cycles", 48'h0a, opens);
  endtask
  task automatic t_level_fft;
    go(1'h0, 2'h1, 32'h0, 32'h1);
    watch(8'h0a, -1);
    chk("open_cycles", 48'h0a, opens);
    chk("valid_cycles", 48'h5, vals);
    chk("last_pulses", 48'h1, lasts);
  endtask
  task automatic t_stop;
    @(posedge clk);
    sp <= 1'h1;
    @(posedge clk);
    sp <= 1'h0;
    @(posedge clk);
    #1;
    chk("running", 48'h0, run);
  endtask
  task automatic t_deny;
    @(posedge clk);
    spn <= 32'h01312d00;
    go(1'h1, 2'h1, 32'h1, 32'h1);
    #1;
    chk("fft_denied", 48'h1, fden);
    chk("running", 48'h0, run);
    @(posedge clk);
    spn <= 32'h000f4240;
  endtask
  task automatic t_sweep_time;
    go(1'h0, 2'h2, 32'h0, 32'h1);
    sw <= 48'hfa9;
    repeat (3) @(posedge clk);
    #1;
    chk("too_short", 48'h1, sshort);
    chk("min_sweep", 48'hfaa, msw);
    @(posedge clk);
    sw <= 48'hfaa;
    repeat (3) @(posedge clk);
    #1;
    chk("too_short", 48'h0, sshort);
  endtask
  task automatic results;
    if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    t_edge_video;
    t_zero_sweep;
    t_fft;
    t_level;
    t_level_fft;
    t_stop;
    t_deny;
    t_sweep_time;
    results;
  end
endmodule // tgc_gate_ctrl_bench
